/* core/scss_sel_sync.v */
// Two-stage sampler of the speed select inputs
`timescale 1ns/1ps
`default_nettype none
module scss_sel_sync (
  input  wire       ref_clk_i,   // System clock
  input  wire       sys_rst_i,   // Sync reset, active high
  input  wire [1:0] sel_i,       // Raw select pair {bit1, bit0}
  output reg  [1:0] sel_o        // Registered select pair
);
  reg [1:0] stage;

  // Both bits move together through two stages
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stage <= 2'h0;
      sel_o <= 2'h0;
    end else begin
      stage <= sel_i;
      sel_o <= stage;
    end
  end
endmodule
`default_nettype wire

/* core/scss_top.v */
// Speed command source selector with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "scss_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Select 00 in analog mode takes the command from the analog reference.
// - Select 00 in zero command mode forces the command to zero.
// - Select 01, 10, 11 picks preset one, two or three.
// - A new preset applies as soon as the select inputs change, no trigger.
// - Presets are signed, clamped to -60000..+60000, 0.1 r/min per count.
// - The analog reference of -10..+10 V is scaled by the analog scaling.
// - The same command is the speed command or, in torque modes, the limit.
// - Position loop gain is 16 bits, range 0..2047, default 35.
// - Manual tuning uses only the user-set gain, no automatic adjustment.
// - Auto tuning starts from the user gain and adjusts it itself.
module scss_top (
  input  wire               ref_clk_i,       // 100 MHz clock
  input  wire               sys_rst_i,       // Sync reset, active high
  input  wire               speed_select_bit0_i, // Select bit 0, ON = 1
  input  wire               speed_select_bit1_i, // Select bit 1, ON = 1
  input  wire signed [15:0] analog_ref_i,    // Converted analog reference
  input  wire signed [15:0] tuned_gain_i,    // Gain from inertia estimator
  input  wire               tuned_valid_i,   // Estimator result pulse
  output reg  signed [31:0] speed_cmd_o,     // Speed command, 0.1 r/min
  output reg                speed_cmd_vld_o, // Command is speed command
  output reg                speed_lim_vld_o, // Command is speed limit
  output reg         [15:0] position_loop_gain_o, // Gain in use, rad/s
  output wire               auto_tune_en_o,  // Auto tuning enabled
  input  wire        [11:0] s_axi_awaddr,    // Write address
  input  wire               s_axi_awvalid,   // Write address valid
  output wire               s_axi_awready,   // Write address ready
  input  wire        [31:0] s_axi_wdata,     // Write data
  input  wire        [3:0]  s_axi_wstrb,     // Write strobes
  input  wire               s_axi_wvalid,    // Write data valid
  output wire               s_axi_wready,    // Write data ready
  output reg         [1:0]  s_axi_bresp,     // Write response
  output reg                s_axi_bvalid,    // Write response valid
  input  wire               s_axi_bready,    // Write response ready
  input  wire        [11:0] s_axi_araddr,    // Read address
  input  wire               s_axi_arvalid,   // Read address valid
  output wire               s_axi_arready,   // Read address ready
  output reg         [31:0] s_axi_rdata,     // Read data
  output reg         [1:0]  s_axi_rresp,     // Read response
  output reg                s_axi_rvalid,    // Read data valid
  input  wire               s_axi_rready     // Read data ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg        [15:0] position_loop_gain;
  reg signed [31:0] preset_speed_one;
  reg signed [31:0] preset_speed_two;
  reg signed [31:0] preset_speed_three;
  reg        [15:0] analog_speed_scaling;
  reg        [2:0]  ctrl;
  reg        [11:0] aw_addr;
  reg               aw_full;
  reg        [31:0] w_data;
  reg        [3:0]  w_strb;
  reg               w_full;
  wire       [1:0]  sel;
  wire       [31:0] wmerged;
  wire              do_write;
  reg signed [31:0] next_cmd;
  reg        [31:0] rd_mux;
  reg               rd_hit;
  wire signed [31:0] analog_scaled;
  wire signed [31:0] preset_wr;
  wire       [31:0] gain_merged;
  wire       [31:0] scale_merged;

  wire zero_command_mode = ctrl[`SCSS_CTRL_ZERO];
  wire torque_mode       = ctrl[`SCSS_CTRL_TORQUE];
  assign auto_tune_en_o  = ctrl[`SCSS_CTRL_AUTO];

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Apply byte strobes to an old word
  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      strb_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          strb_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Clamp a signed word to the preset range
  function signed [31:0] clamp_preset;
    input signed [31:0] v;
    begin
      if (v > `SCSS_PRESET_MAX) begin
        clamp_preset = `SCSS_PRESET_MAX;
      end else if (v < `SCSS_PRESET_MIN) begin
        clamp_preset = `SCSS_PRESET_MIN;
      end else begin
        clamp_preset = v;
      end
    end
  endfunction

  // Clamp a gain value to 0..2047
  function [15:0] clamp_gain;
    input [31:0] v;
    begin
      if (v > {16'h0000, `SCSS_GAIN_MAX}) begin
        clamp_gain = `SCSS_GAIN_MAX;
      end else begin
        clamp_gain = v[15:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Select input sampling
  scss_sel_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .sel_i     ({speed_select_bit1_i, speed_select_bit0_i}),
    .sel_o     (sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel capture
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      aw_full <= 1'b0;
      aw_addr <= 12'h000;
      w_full  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and response
  assign wmerged   = w_data;
  assign preset_wr = clamp_preset(strb_merge(32'h00000000, w_data, w_strb));
  // Full words after strobes, upper bits kept for the gain clamp
  assign gain_merged  = strb_merge({16'h0000, position_loop_gain}, wmerged,
                                   w_strb);
  assign scale_merged = strb_merge({16'h0000, analog_speed_scaling}, wmerged,
                                   w_strb);

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      position_loop_gain   <= `SCSS_GAIN_RST;
      preset_speed_one     <= 32'h00000000;
      preset_speed_two     <= 32'h00000000;
      preset_speed_three   <= 32'h00000000;
      analog_speed_scaling <= `SCSS_SCALE_RST;
      ctrl                 <= 3'h0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `SCSS_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SCSS_RESP_OKAY;
        case (aw_addr)
          `SCSS_ADDR_GAIN: begin
            position_loop_gain <= clamp_gain(gain_merged);
          end
          `SCSS_ADDR_PRESET1: preset_speed_one   <= preset_wr;
          `SCSS_ADDR_PRESET2: preset_speed_two   <= preset_wr;
          `SCSS_ADDR_PRESET3: preset_speed_three <= preset_wr;
          `SCSS_ADDR_SCALE: begin
            analog_speed_scaling <= scale_merged[15:0];
          end
          `SCSS_ADDR_CTRL: begin
            if (w_strb[0]) begin
              ctrl <= w_data[2:0];
            end
          end
          `SCSS_ADDR_STATUS, `SCSS_ADDR_CMD, `SCSS_ADDR_GAIN_USED: begin
            s_axi_bresp <= `SCSS_RESP_OKAY; // Read-only, write ignored
          end
          default: s_axi_bresp <= `SCSS_RESP_SLVERR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `SCSS_ADDR_GAIN:      rd_mux = {16'h0000, position_loop_gain};
      `SCSS_ADDR_PRESET1:   rd_mux = preset_speed_one;
      `SCSS_ADDR_PRESET2:   rd_mux = preset_speed_two;
      `SCSS_ADDR_PRESET3:   rd_mux = preset_speed_three;
      `SCSS_ADDR_SCALE:     rd_mux = {16'h0000, analog_speed_scaling};
      `SCSS_ADDR_CTRL:      rd_mux = {29'h00000000, ctrl};
      `SCSS_ADDR_STATUS:    rd_mux = {28'h0000000, speed_lim_vld_o,
                                      speed_cmd_vld_o, sel};
      `SCSS_ADDR_CMD:       rd_mux = speed_cmd_o;
      `SCSS_ADDR_GAIN_USED: rd_mux = {16'h0000, position_loop_gain_o};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read response register
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SCSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  // Full scale 16-bit reference times scaling, divided by 2^8
  assign analog_scaled = (analog_ref_i * $signed({1'b0,
    analog_speed_scaling})) >>> `SCSS_SCALE_SHIFT;

  always @* begin
    case (sel)
      `SCSS_SRC_ANALOG: begin
        if (zero_command_mode) begin
          next_cmd = 32'h00000000;
        end else begin
          next_cmd = analog_scaled;
        end
      end
      `SCSS_SRC_PRE1: next_cmd = preset_speed_one;
      `SCSS_SRC_PRE2: next_cmd = preset_speed_two;
      `SCSS_SRC_PRE3: next_cmd = preset_speed_three;
      default:        next_cmd = 32'h00000000;
    endcase
  end

  // Command updated every cycle, no trigger needed
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      speed_cmd_o     <= 32'h00000000;
      speed_cmd_vld_o <= 1'b0;
      speed_lim_vld_o <= 1'b0;
    end else begin
      speed_cmd_o     <= next_cmd;
      speed_cmd_vld_o <= !torque_mode;
      speed_lim_vld_o <= torque_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain in use: manual keeps user value, auto adopts estimator results
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      position_loop_gain_o <= `SCSS_GAIN_RST;
    end else if (!auto_tune_en_o) begin
      position_loop_gain_o <= position_loop_gain;
    end else if (tuned_valid_i) begin
      // Negative estimate floors at zero rather than saturating to full gain
      position_loop_gain_o <= clamp_gain(tuned_gain_i[15] ? 32'h00000000 :
                                         {16'h0000, tuned_gain_i});
    end
  end

  // Entering auto mode starts from the user value
  // (handled above: gain in use equals user value until first result)
endmodule
`default_nettype wire

/* inc/scss_regs.vh */
// Register map and constants of the speed command source selector
`ifndef SCSS_REGS_VH
`define SCSS_REGS_VH

// Byte addresses (AXI4-Lite, one word each)
`define SCSS_ADDR_GAIN       12'h200
`define SCSS_ADDR_PRESET1    12'h204
`define SCSS_ADDR_PRESET2    12'h208
`define SCSS_ADDR_PRESET3    12'h20C
`define SCSS_ADDR_SCALE      12'h210
`define SCSS_ADDR_CTRL       12'h214
`define SCSS_ADDR_STATUS     12'h218
`define SCSS_ADDR_CMD        12'h21C
`define SCSS_ADDR_GAIN_USED  12'h220

// Reset values and limits
`define SCSS_GAIN_RST        16'h0023
`define SCSS_GAIN_MAX        16'h07FF
`define SCSS_PRESET_MAX      32'sh0000EA60
`define SCSS_PRESET_MIN      32'shFFFF15A0
`define SCSS_SCALE_RST       16'h0100
`define SCSS_SCALE_SHIFT     8

// Control register fields
`define SCSS_CTRL_ZERO       0
`define SCSS_CTRL_TORQUE     1
`define SCSS_CTRL_AUTO       2

// Source select codes
`define SCSS_SRC_ANALOG      2'h0
`define SCSS_SRC_PRE1        2'h1
`define SCSS_SRC_PRE2        2'h2
`define SCSS_SRC_PRE3        2'h3

// AXI responses
`define SCSS_RESP_OKAY       2'h0
`define SCSS_RESP_SLVERR     2'h2

`endif

/* verification/scss_ctl_model.sv */
// Motion controller model driving the speed select pins
`timescale 1ns/1ps
`default_nettype none
module scss_ctl_model (
  input  wire logic       ref_clk_i,                  // Clock
  input  wire logic [1:0] code_i,                     // Wanted code
  output var  logic       speed_select_bit0_o = 1'b0, // Bit 0, ON is 1
  output var  logic       speed_select_bit1_o = 1'b0  // Bit 1, ON is 1
);
  // Both pins move together, high for ON
  always @(posedge ref_clk_i) begin
    speed_select_bit0_o <= code_i[0];
    speed_select_bit1_o <= code_i[1];
  end
endmodule
`default_nettype wire

/* verification/scss_top_props.sv */
// Property checker for the speed command source selector
`timescale 1ns/1ps
`default_nettype none
module scss_top_props (
  input wire logic               ref_clk_i,            // Clock
  input wire logic               sys_rst_i,            // Reset
  input wire logic               speed_cmd_vld_o,      // Command flag
  input wire logic               speed_lim_vld_o,      // Limit flag
  input wire logic        [15:0] position_loop_gain_o, // Gain in use
  input wire logic               auto_tune_en_o,       // Auto tuning
  input wire logic signed [15:0] tuned_gain_i,         // Estimator gain
  input wire logic               tuned_valid_i,        // Estimator pulse
  input wire logic               s_axi_awvalid,        // AW valid
  input wire logic               s_axi_awready,        // AW ready
  input wire logic               s_axi_wvalid,         // W valid
  input wire logic               s_axi_wready,         // W ready
  input wire logic               s_axi_bvalid,         // B valid
  input wire logic               s_axi_bready,         // B ready
  input wire logic               s_axi_arvalid,        // AR valid
  input wire logic               s_axi_arready,        // AR ready
  input wire logic               s_axi_rvalid          // R valid
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // One meaning of the command at a time
  property p_excl;
    !(speed_cmd_vld_o && speed_lim_vld_o);
  endproperty
  a_excl: assert property (p_excl) else $error("both flags high");
  // Gain never leaves its range
  property p_gain_max;
    position_loop_gain_o <= 16'h07FF;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("gain high");
  // Manual tuning ignores the estimator
  property p_manual;
    !auto_tune_en_o && !s_axi_bvalid |=> $stable(position_loop_gain_o);
  endproperty
  a_manual: assert property (p_manual) else $error("gain moved");
  // Auto tuning takes the estimate
  property p_auto;
    auto_tune_en_o && tuned_valid_i && !s_axi_bvalid &&
      tuned_gain_i >= 16'sh0000 && tuned_gain_i <= 16'sh07FF
      |=> position_loop_gain_o == $unsigned($past(tuned_gain_i));
  endproperty
  a_auto: assert property (p_auto) else $error("estimate lost");
  // Write answered two cycles after both parts are taken
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("no write answer");
  // No new write taken while answering
  property p_b_ref;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_ref: assert property (p_b_ref) else $error("write taken early");
  // Write answer leaves once accepted
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("answer stuck");
  // Read answered one cycle after the address
  property p_ar_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_lat: assert property (p_ar_lat) else $error("no read answer");
endmodule
bind scss_top scss_top_props u_scss_top_props (.*);
`default_nettype wire

/* verification/speed_command_source_select_test.sv */
// Self-checking bench of the speed command source selector
`timescale 1ns/1ps
`default_nettype none
`include "scss_regs.vh"
module speed_command_source_select_test;
  logic ref_clk_i, sys_rst_i, speed_select_bit0_i, speed_select_bit1_i;
  logic signed [15:0] analog_ref_i, tuned_gain_i;
  logic signed [31:0] speed_cmd_o;
  logic tuned_valid_i, speed_cmd_vld_o, speed_lim_vld_o, auto_tune_en_o;
  logic [15:0] position_loop_gain_o, seed;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, code, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  integer errors, total_checks, i, e, scl;
  integer pre [1:3];
  scss_top u_scss_top (.*);
  scss_ctl_model u_scss_ctl_model (.ref_clk_i(ref_clk_i), .code_i(code),
    .speed_select_bit0_o(speed_select_bit0_i),
    .speed_select_bit1_o(speed_select_bit1_i));
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic integer clamp(input integer v);
    clamp = v > 60000 ? 60000 : (v < -60000 ? -60000 : v);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write, waits for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    integer n;
    logic ah, wh, bh;
    logic [1:0] xr;
    n = 0;
    bh = 1'b0;
    xr = (a >= `SCSS_ADDR_GAIN && a <= `SCSS_ADDR_GAIN_USED) ?
         `SCSS_RESP_OKAY : `SCSS_RESP_SLVERR;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!bh && n < 200) begin
      @(negedge ref_clk_i);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge ref_clk_i);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
    end
    chk({29'h0, !bh, rsp}, {30'h0, xr});
  endtask
  // Bus read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                     input logic [1:0] xr);
    integer n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rh && n < 200) begin
      @(negedge ref_clk_i);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk_i);
      if (ah) s_axi_arvalid <= 1'b0;
      n++;
    end
    chk(rd, x);
    chk({29'h0, !rh, rsp}, {30'h0, xr});
  endtask
  // New code, then command after controller and sync delay
  task automatic sel(input logic [1:0] c, input integer x);
    code <= c;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(speed_cmd_o, x[31:0]);
    @(posedge ref_clk_i);
  endtask
  // Estimator pulse, then gain in use
  task automatic tune(input logic auto);
    seed = lfsr(seed);
    tuned_gain_i <= {5'h00, seed[10:0]};
    tuned_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    tuned_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({16'h0, position_loop_gain_o},
        auto ? {21'h0, seed[10:0]} : 32'h7D);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    seed = 16'h0062;
    sys_rst_i = 1'b1;
    code = 2'h0;
    analog_ref_i = 16'sh0000;
    tuned_gain_i = 16'sh0000;
    tuned_valid_i = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk({16'h0, position_loop_gain_o}, 32'h23);
    rdc(`SCSS_ADDR_GAIN, 32'h23, `SCSS_RESP_OKAY);
    rdc(12'h300, 32'h0, `SCSS_RESP_SLVERR);
    wr(12'h300, 32'h1);
    wr(`SCSS_ADDR_GAIN, 32'hBB8);
    rdc(`SCSS_ADDR_GAIN, 32'h7FF, `SCSS_RESP_OKAY);
    wr(`SCSS_ADDR_GAIN, 32'h7D);
    s_axi_wstrb <= 4'h1;
    wr(`SCSS_ADDR_PRESET1, 32'h12345678);
    s_axi_wstrb <= 4'hF;
    rdc(`SCSS_ADDR_PRESET1, 32'h78, `SCSS_RESP_OKAY);
    $display("test registers done");
    for (i = 1; i <= 3; i++) begin
      seed = lfsr(seed);
      e = (i == 1) ? 60001 : (i == 2) ? -60001 : $signed(seed);
      pre[i] = clamp(e);
      wr(`SCSS_ADDR_GAIN + 12'(4 * i), e[31:0]);
      rdc(`SCSS_ADDR_GAIN + 12'(4 * i), pre[i], `SCSS_RESP_OKAY);
    end
    for (i = 1; i <= 3; i++)
      sel(i[1:0], pre[i]);
    chk({31'h0, speed_cmd_vld_o}, 32'h1);
    $display("test presets done");
    for (i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      analog_ref_i <= $signed(seed);
      scl = (i == 0) ? 256 : seed[9:0];
      wr(`SCSS_ADDR_SCALE, scl[31:0]);
      sel(2'h0, ($signed(seed) * scl) >>> 8);
    end
    wr(`SCSS_ADDR_CTRL, 32'h1);
    sel(2'h0, 0);
    wr(`SCSS_ADDR_CTRL, 32'h2);
    sel(2'h1, pre[1]);
    chk({30'h0, speed_lim_vld_o, speed_cmd_vld_o}, 32'h2);
    $display("test sources done");
    tune(1'b0);
    wr(`SCSS_ADDR_CTRL, 32'h4);
    chk({31'h0, auto_tune_en_o}, 32'h1);
    chk({16'h0, position_loop_gain_o}, 32'h7D);
    tune(1'b1);
    $display("test tuning done");
    conclude();
  end
endmodule
`default_nettype wire
